// file: twmr_defs.vh
// Purpose: constants for the two-wire master receiver block
// Assumes: register offsets are local choices; eight-bit registers
// Notes: status codes carry zero prescaler bits
`ifndef TWMR_DEFS_VH
`define TWMR_DEFS_VH

// register offsets on the plain register port
`define TWMR_ADDR_CONTROL 2'h0
`define TWMR_ADDR_STATUS 2'h1
`define TWMR_ADDR_DATA 2'h2
`define TWMR_ADDR_BITRATE 2'h3

// control register bit positions
`define TWMR_B_DONE 7
`define TWMR_B_ACKEN 6
`define TWMR_B_START 5
`define TWMR_B_STOP 4
`define TWMR_B_WCOL 3
`define TWMR_B_EN 2
`define TWMR_B_IE 0

// reset values
`define TWMR_RST_CONTROL 8'h00
`define TWMR_RST_DATA 8'hff
`define TWMR_RST_BITRATE 8'h0f

// status codes
`define TWMR_ST_START 8'h08
`define TWMR_ST_RSTART 8'h10
`define TWMR_ST_WADDR_ACK 8'h18
`define TWMR_ST_WADDR_NACK 8'h20
`define TWMR_ST_ARB_LOST 8'h38
`define TWMR_ST_RADDR_ACK 8'h40
`define TWMR_ST_RADDR_NACK 8'h48
`define TWMR_ST_DATA_ACK 8'h50
`define TWMR_ST_DATA_NACK 8'h58
`define TWMR_ST_IDLE 8'hf8

`endif

// file: twmr_sync.v
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: inputs are asynchronous levels
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module twmr_sync #(
	parameter W = 2
) (
	input wire clk,
	input wire rst_n,
	input wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// idle bus lines are high, so reset to ones
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= {W{1'b1}};
			sync_q <= {W{1'b1}};
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule
`default_nettype wire

// file: twmr_top.v
// Purpose: master receiver engine of a two-wire serial unit
// Assumes: registers reached over a plain strobe port, one-cycle read data
// Notes: slave modes are outside; arbitration loss releases the bus
//
// Contract
// - read bit selects receive, write selects send
// - start request waits for free bus
// - start sent sets flag, status 0x08
// - writing one clears flag, resumes transfer
// - read address sent: 0x38, 0x40, 0x48
// - received byte readable while flag set
// - last byte answered with nack
// - stop request ends transfer with stop
// - stop request bit self-clears after stop
// - start with flag clear gives repeated start
// - in 0x10 write address switches send
// - 0x38: release or start when free
// - 0x40: receive byte, ack per enable
// - 0x48: restart, stop, or stop-start
// - 0x50: next byte, ack per enable
// - 0x58: restart, stop, or stop-start
// - data write with flag low discarded
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "twmr_defs.vh"
module twmr_top #(
	parameter BUS_FREE_CYC = 250
) (
	input wire core_clk,
	input wire arst_n,
	input wire [1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire scl_i,
	output wire scl_o,
	output wire scl_oe,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe,
	output wire irq
);
	// bus engine states
	localparam S_IDLE = 4'd0;
	localparam S_WAITFREE = 4'd1;
	localparam S_START = 4'd2;
	localparam S_BIT = 4'd3;
	localparam S_HOLD = 4'd4;
	localparam S_STOP = 4'd5;
	localparam S_RSTART = 4'd6;

	reg rst_m_q, rst_q;
	wire rst_n = rst_q;
	wire scl_s, sda_s;

	// release reset through two flops
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_m_q <= 1'b0;
			rst_q <= 1'b0;
		end
		else
		begin
			rst_m_q <= 1'b1;
			rst_q <= rst_m_q;
		end
	end

	twmr_sync #(.W(2)) u_sync (
		.clk(core_clk),
		.rst_n(rst_n),
		.async_in({scl_i, sda_i}),
		.sync_out({scl_s, sda_s})
	);

	reg done_q, acken_q, start_q, stop_q, wcol_q, en_q, ie_q;
	reg [7:0] status_q, data_q, bitrate_q;
	reg [3:0] state_q;
	reg [1:0] phase_q;
	reg [7:0] qcnt_q;
	reg [3:0] bit_q;
	reg [7:0] shift_q;
	reg rx_q, last_dir_q, nack_q;
	reg scl_low_q, sda_low_q;
	reg [8:0] free_q;

	wire wr_ctl = reg_wr && (reg_addr == `TWMR_ADDR_CONTROL);
	wire wr_dat = reg_wr && (reg_addr == `TWMR_ADDR_DATA);
	wire clr_done = wr_ctl && reg_wdata[`TWMR_B_DONE];
	wire tick = (qcnt_q == 8'h00);
	// widen the counter rather than slicing the parameter
	wire bus_free = ({23'h00_0000, free_q} >= BUS_FREE_CYC);
	wire set_done;
	reg set_done_r;
	reg [7:0] set_status_r;
	assign set_done = set_done_r;

	// bus-free detect: lines idle high long enough means nobody owns the bus
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			free_q <= 9'h000;
		else if (!(scl_s && sda_s))
			free_q <= 9'h000; // any activity restarts the wait
		else if (!bus_free)
			free_q <= free_q + 9'h001;
	end

	// software register writes; hardware set of flag wins over clear
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			done_q <= 1'b0;
			acken_q <= 1'b0;
			start_q <= 1'b0;
			stop_q <= 1'b0;
			wcol_q <= 1'b0;
			en_q <= 1'b0;
			ie_q <= 1'b0;
			bitrate_q <= `TWMR_RST_BITRATE;
		end
		else
		begin
			if (wr_ctl)
			begin
				acken_q <= reg_wdata[`TWMR_B_ACKEN];
				start_q <= reg_wdata[`TWMR_B_START];
				stop_q <= reg_wdata[`TWMR_B_STOP];
				en_q <= reg_wdata[`TWMR_B_EN];
				ie_q <= reg_wdata[`TWMR_B_IE];
			end
			if (wr_ctl && !reg_wdata[`TWMR_B_EN])
				stop_q <= 1'b0;
			else if (state_q == S_STOP && phase_q == 2'd2 && tick)
				stop_q <= 1'b0;
			if (set_done)
				done_q <= 1'b1;
			else if (clr_done)
				done_q <= 1'b0;
			if (wr_dat && !done_q)
				wcol_q <= 1'b1;
			else if (wr_dat)
				wcol_q <= 1'b0;
			if (reg_wr && reg_addr == `TWMR_ADDR_BITRATE)
				bitrate_q <= reg_wdata;
		end
	end

	// data register: software loads only while flag set, hardware loads rx byte
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			data_q <= `TWMR_RST_DATA;
		else if (set_done && rx_q)
			data_q <= shift_q;
		else if (wr_dat && done_q)
			data_q <= reg_wdata;
	end

	// next flag event and its status code
	always @*
	begin
		set_done_r = 1'b0;
		set_status_r = status_q;
		if (state_q == S_START && phase_q == 2'd1 && tick)
		begin
			set_done_r = 1'b1;
			set_status_r = `TWMR_ST_START;
		end
		else if (state_q == S_RSTART && phase_q == 2'd3 && tick)
		begin
			set_done_r = 1'b1;
			set_status_r = `TWMR_ST_RSTART;
		end
		else if (state_q == S_BIT && bit_q == 4'd8 && phase_q == 2'd3 && tick)
		begin
			set_done_r = 1'b1;
			if (rx_q)
				set_status_r = nack_q ? `TWMR_ST_DATA_NACK : `TWMR_ST_DATA_ACK;
			else if (last_dir_q)
				set_status_r = sda_s ? `TWMR_ST_RADDR_NACK : `TWMR_ST_RADDR_ACK;
			else
				set_status_r = sda_s ? `TWMR_ST_WADDR_NACK : `TWMR_ST_WADDR_ACK;
		end
		else if (state_q == S_BIT && phase_q == 2'd2 && tick && sda_oe == 1'b0
			&& !rx_q && bit_q != 4'd8 && shift_q[7] && !sda_s)
		begin
			set_done_r = 1'b1;
			set_status_r = `TWMR_ST_ARB_LOST;
		end
	end

	// bus engine: quarter-bit phases paced by the bit rate register
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= S_IDLE;
			phase_q <= 2'd0;
			qcnt_q <= 8'h00;
			bit_q <= 4'd0;
			shift_q <= 8'h00;
			rx_q <= 1'b0;
			last_dir_q <= 1'b0;
			nack_q <= 1'b0;
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
			status_q <= `TWMR_ST_IDLE;
		end
		else
		begin
			if (set_done)
				status_q <= set_status_r;
			qcnt_q <= tick ? bitrate_q : qcnt_q - 8'h01;
			if (!en_q)
			begin
				state_q <= S_IDLE;
				scl_low_q <= 1'b0;
				sda_low_q <= 1'b0;
			end
			else
			begin
				case (state_q)
				S_IDLE:
				begin
					scl_low_q <= 1'b0;
					sda_low_q <= 1'b0;
					if (start_q && !done_q)
						state_q <= S_WAITFREE;
				end
				S_WAITFREE:
				begin
					phase_q <= 2'd0;
					if (bus_free && tick)
						state_q <= S_START;
				end
				S_START:
				begin
					// pull data low while clock high, then clock low
					if (tick)
					begin
						phase_q <= phase_q + 2'd1;
						if (phase_q == 2'd0)
							sda_low_q <= 1'b1;
						else
						begin
							scl_low_q <= 1'b1;
							state_q <= S_HOLD;
						end
					end
				end
				S_HOLD:
				begin
					// clock held low until software clears the flag; released at once after arbitration loss
					phase_q <= 2'd0;
					if (status_q == `TWMR_ST_ARB_LOST)
					begin
						scl_low_q <= 1'b0;
						sda_low_q <= 1'b0;
						if (!done_q)
							state_q <= start_q ? S_WAITFREE : S_IDLE;
					end
					else if (!done_q && stop_q)
						state_q <= S_STOP;
					else if (!done_q && start_q)
						state_q <= S_RSTART;
					else if (!done_q)
					begin
						state_q <= S_BIT;
						bit_q <= 4'd0;
						if (status_q == `TWMR_ST_START || status_q == `TWMR_ST_RSTART)
						begin
							// address byte taken from data register
							shift_q <= data_q;
							rx_q <= 1'b0;
							last_dir_q <= data_q[0];
						end
						else if (last_dir_q)
						begin
							shift_q <= 8'hff;
							rx_q <= 1'b1;
						end
						else
						begin
							shift_q <= data_q;
							rx_q <= 1'b0;
						end
					end
				end
				S_BIT:
				begin
					// phase 0 sets data, 1 raises clock, 2 samples, 3 lowers clock
					if (tick)
					begin
						phase_q <= phase_q + 2'd1;
						if (phase_q == 2'd0)
						begin
							if (bit_q == 4'd8)
							begin
								sda_low_q <= rx_q & acken_q;
								// kept apart so the received byte stays intact
								nack_q <= !acken_q;
							end
							else
								sda_low_q <= !rx_q & !shift_q[7];
						end
						else if (phase_q == 2'd1)
							scl_low_q <= 1'b0;
						else if (phase_q == 2'd2)
						begin
							if (set_done)
							begin
								state_q <= S_HOLD; // arbitration lost
								scl_low_q <= 1'b0;
								sda_low_q <= 1'b0;
							end
							else if (bit_q != 4'd8)
								shift_q <= {shift_q[6:0], sda_s};
						end
						else
						begin
							scl_low_q <= 1'b1;
							if (bit_q == 4'd8)
								state_q <= S_HOLD;
							else
								bit_q <= bit_q + 4'd1;
						end
					end
				end
				S_STOP:
				begin
					// data low, clock released, then data released
					if (tick)
					begin
						phase_q <= phase_q + 2'd1;
						if (phase_q == 2'd0)
							sda_low_q <= 1'b1;
						else if (phase_q == 2'd1)
							scl_low_q <= 1'b0;
						else if (phase_q == 2'd2)
						begin
							sda_low_q <= 1'b0;
							status_q <= `TWMR_ST_IDLE;
							state_q <= start_q ? S_WAITFREE : S_IDLE;
						end
					end
				end
				S_RSTART:
				begin
					// release data, release clock, then start again
					if (tick)
					begin
						phase_q <= phase_q + 2'd1;
						if (phase_q == 2'd0)
							sda_low_q <= 1'b0;
						else if (phase_q == 2'd1)
							scl_low_q <= 1'b0;
						else if (phase_q == 2'd2)
							sda_low_q <= 1'b1;
						else
						begin
							scl_low_q <= 1'b1;
							state_q <= S_HOLD;
						end
					end
				end
				default:
					state_q <= S_IDLE;
				endcase
			end
		end
	end

	// open drain: drive low only
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_low_q;
	assign sda_oe = sda_low_q;

	assign irq = done_q & ie_q;

	// registered read data, one cycle after the strobe
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
			`TWMR_ADDR_CONTROL:
				reg_rdata <= {done_q, acken_q, start_q, stop_q, wcol_q, en_q, 1'b0, ie_q};
			`TWMR_ADDR_STATUS:
				reg_rdata <= status_q; // prescaler bits read zero
			`TWMR_ADDR_DATA:
				reg_rdata <= data_q;
			default:
				reg_rdata <= bitrate_q;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end
endmodule
`default_nettype wire

// file: twmr_top_props.sv
// Purpose: port checker for the master receiver
// Assumes: bench keeps irq_enable set, so irq mirrors the flag
// Notes: attached to every twmr_top by bind
`timescale 1ns/1ps
`default_nettype none
module twmr_top_props (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic scl_o,
	input wire logic sda_o,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// read data only in the slot after a read
	property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	// open-drain: only the enables move the lines
	property p_lines; scl_o == 1'b0 && sda_o == 1'b0; endproperty
	a_lines: assert property (p_lines) else $error("line driven high");
	property p_irq_flag; reg_rd && reg_addr == 2'h0 && irq |=> reg_rdata[7] && reg_rdata[0];
	endproperty
	a_irq_flag: assert property (p_irq_flag) else $error("irq without flag");
	property p_no_irq; reg_rd && reg_addr == 2'h0 && !irq |=> !(reg_rdata[7] && reg_rdata[0]);
	endproperty
	a_no_irq: assert property (p_no_irq) else $error("flag without irq");
	// suspended transfer waits for software
	property p_hold; irq && !(reg_wr && reg_addr == 2'h0) |=> irq; endproperty
	a_hold: assert property (p_hold) else $error("flag dropped alone");
	property p_clear; irq && reg_wr && reg_addr == 2'h0 && reg_wdata[7] |=> !irq; endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");
	property p_wcol;
		reg_wr && reg_addr == 2'h2 && !irq ##[1:2] reg_rd && reg_addr == 2'h0 |=> reg_rdata[3];
	endproperty
	a_wcol: assert property (p_wcol) else $error("collision not flagged");
	property p_status;
		reg_rd && reg_addr == 2'h1 && irq |=>
			reg_rdata inside {8'h08, 8'h10, 8'h38, 8'h40, 8'h48, 8'h50, 8'h58};
	endproperty
	a_status: assert property (p_status) else $error("bad status code");
	c_irq: cover property ($rose(irq));
	c_wcol: cover property (reg_wr && reg_addr == 2'h2 && !irq);
	c_status: cover property (reg_rd && reg_addr == 2'h1 && irq);
endmodule
bind twmr_top twmr_top_props twmr_top_props_i (.core_clk(core_clk), .arst_n(arst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .scl_o(scl_o), .sda_o(sda_o), .irq(irq));
`default_nettype wire

// file: twmr_slave.sv
// Purpose: behavioural slave sender on the two-wire bus
// Assumes: master moves data only while the clock line is low
// Notes: bytes start at 8'hc5 and step by 8'h11 per byte
`timescale 1ns/1ps
`default_nettype none
module twmr_slave #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	input wire logic scl,
	input wire logic sda,
	output logic sda_pull
);
	logic [3:0] bit_n;
	logic [7:0] sh, tx;
	logic addr_ph, rd_ph;
	initial
	begin
		sda_pull = 1'b0;
		bit_n = 4'h0;
		addr_ph = 1'b0;
		rd_ph = 1'b0;
	end
	// start or stop framing resets the frame
	always @(negedge sda) if (scl) {bit_n, addr_ph, rd_ph, sda_pull} = {4'h0, 3'b100};
	always @(posedge sda) if (scl) {addr_ph, rd_ph, sda_pull} = 3'b000;
	// sample on rising clock; master nack ends sending
	always @(posedge scl)
	begin
		if (bit_n < 4'h8) sh = {sh[6:0], sda};
		else if (rd_ph && sda) rd_ph = 1'b0;
		else tx = tx + 8'h11; // address ack also steps, hence the base below
		bit_n = (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
	end
	// drive on falling clock; released line floats high
	always @(negedge scl)
	begin
		sda_pull = 1'b0;
		if (bit_n == 4'h8 && addr_ph)
		begin
			addr_ph = 1'b0;
			if (sh[7:1] == ADDR) {sda_pull, rd_ph, tx} = {1'b1, sh[0], 8'hb4};
		end
		else if (rd_ph && bit_n < 4'h8) sda_pull = !tx[4'h7 - bit_n];
	end
endmodule
`default_nettype wire

// file: twmr_test.sv
// Purpose: self-checking bench for the master receiver
// Assumes: bit rate 1 gives a 160 ns bus bit
// Notes: bus-free wait shortened to 10 cycles
`timescale 1ns/1ps
`default_nettype none
`include "twmr_defs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("FAIL %0t got %h exp %h", $time, g, e); end end
module twmr_test;
	logic core_clk, arst_n, reg_wr, reg_rd, ext_pull;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, v;
	wire [7:0] reg_rdata;
	wire scl_o, scl_oe, sda_o, sda_oe, irq, sda_pull;
	wire scl = !scl_oe;
	// ext_pull stands for a rival master holding data low
	wire sda = !(sda_oe || sda_pull || ext_pull);
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	twmr_top #(.BUS_FREE_CYC(10)) twmr_top_i (.core_clk(core_clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
	twmr_slave twmr_slave_i (.scl(scl), .sda(sda), .sda_pull(sda_pull));
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard, well above the expected run
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// control write, then wait for the flag and check the status
	task automatic go(input logic [7:0] c, input logic [7:0] s);
		int i;
		wr(2'h0, c);
		// the clear lands at this edge; poll only once it has settled
		@(negedge core_clk);
		for (i = 0; i < 3000 && irq !== 1'b1; i++) @(negedge core_clk);
		rd(2'h1, v);
		`CHK(v, s)
	endtask
	task automatic stop_wait();
		int i;
		wr(2'h0, 8'h95);
		for (i = 0; i < 50; i++) begin rd(2'h0, v); if (!v[4]) break; end
		`CHK(v[4], 1'b0)
		`CHK({scl, sda}, 2'b11)
	endtask
	task automatic t_regs();
		rd(2'h0, v); `CHK(v, `TWMR_RST_CONTROL)
		rd(2'h1, v); `CHK(v, `TWMR_ST_IDLE)
		rd(2'h2, v); `CHK(v, `TWMR_RST_DATA)
		rd(2'h3, v); `CHK(v, `TWMR_RST_BITRATE)
		wr(2'h3, 8'h01);
		rd(2'h3, v); `CHK(v, 8'h01)
		wr(2'h2, 8'h3c);
		rd(2'h0, v); `CHK(v[3], 1'b1)
		rd(2'h2, v); `CHK(v, `TWMR_RST_DATA)
	endtask
	// read n bytes, nack on the last
	task automatic t_recv(input int n);
		logic [7:0] e;
		e = 8'hc5;
		go(8'ha5, `TWMR_ST_START);
		wr(2'h2, 8'h55);
		rd(2'h0, v); `CHK(v[3], 1'b0)
		go(8'hc5, `TWMR_ST_RADDR_ACK);
		for (int i = 0; i < n; i++)
		begin
			if (i == n - 1) go(8'h85, `TWMR_ST_DATA_NACK);
			else go(8'hc5, `TWMR_ST_DATA_ACK);
			rd(2'h2, v); `CHK(v, e)
			e = e + 8'h11;
		end
		stop_wait();
	endtask
	// absent slave, restart, then stop followed by start
	task automatic t_nack();
		go(8'ha5, `TWMR_ST_START);
		wr(2'h2, 8'h13);
		go(8'hc5, `TWMR_ST_RADDR_NACK);
		go(8'ha5, `TWMR_ST_RSTART);
		wr(2'h2, 8'h55);
		go(8'h85, `TWMR_ST_RADDR_ACK);
		go(8'h85, `TWMR_ST_DATA_NACK);
		rd(2'h2, v); `CHK(v, 8'hc5)
		go(8'hb5, `TWMR_ST_START);
		wr(2'h2, 8'h13);
		go(8'h85, `TWMR_ST_RADDR_NACK);
		go(8'hb5, `TWMR_ST_START);
		stop_wait();
	endtask
	// rival master pulls data low during the address, then a retry
	task automatic t_arb();
		go(8'ha5, `TWMR_ST_START);
		wr(2'h2, 8'h55);
		ext_pull <= 1'b1;
		go(8'hc5, `TWMR_ST_ARB_LOST);
		`CHK({scl, sda}, 2'b10)
		ext_pull <= 1'b0;
		go(8'ha5, `TWMR_ST_START);
		stop_wait();
	endtask
	initial
	begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = 12'h000;
		ext_pull = 1'b0;
		arst_n = 1'b0;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_regs();
		t_recv(1);
		t_recv(3);
		t_nack();
		t_arb();
		end_of_test();
	end
endmodule
`default_nettype wire
